// ---- core/mrb_defs.vh ----
// register indices, attribute masks and reset values of the management register bank
`ifndef MRB_DEFS_VH
`define MRB_DEFS_VH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define MRB_IDX_W        5
`define MRB_IDX_CTL      5'h00
`define MRB_IDX_STS      5'h01
`define MRB_IDX_IDH      5'h02
`define MRB_IDX_IDL      5'h03
`define MRB_IDX_ADV      5'h04
`define MRB_IDX_LPA      5'h05
`define MRB_IDX_EXP      5'h06
`define MRB_IDX_MCS      5'h11
`define MRB_IDX_SMD      5'h12
`define MRB_IDX_SEC      5'h1A
`define MRB_IDX_CSI      5'h1B
`define MRB_IDX_ISR      5'h1D
`define MRB_IDX_IMR      5'h1E
`define MRB_IDX_SCS      5'h1F

// ----------------------------------------------------------------------
// common values
// ----------------------------------------------------------------------
`define MRB_ZERO         16'h0000
`define MRB_ONES         16'hFFFF
`define MRB_ONE          16'h0001

// ----------------------------------------------------------------------
// basic control
// ----------------------------------------------------------------------
`define MRB_CTL_SRST_M   16'h8000
`define MRB_CTL_LOOP_M   16'h4000
`define MRB_CTL_SPD_M    16'h2000
`define MRB_CTL_ANEN_M   16'h1000
`define MRB_CTL_PDN_M    16'h0800
`define MRB_CTL_ISO_M    16'h0400
`define MRB_CTL_ANRS_M   16'h0200
`define MRB_CTL_DPX_M    16'h0100
`define MRB_CTL_RW       16'h7D00
`define MRB_CTL_SC       16'h8200
`define MRB_CTL_RST      16'h3100

// ----------------------------------------------------------------------
// basic status
// ----------------------------------------------------------------------
`define MRB_STS_CAPS     16'h7809
`define MRB_STS_ANDN_M   16'h0020
`define MRB_STS_RFLT_M   16'h0010
`define MRB_STS_LINK_M   16'h0004
`define MRB_STS_JAB_M    16'h0002
`define MRB_STS_RO       16'h7829
`define MRB_STS_LH       16'h0012
`define MRB_STS_LL       16'h0004

// ----------------------------------------------------------------------
// identifier (values arbitrary), advertisement, expansion
// ----------------------------------------------------------------------
`define MRB_IDH_RST      16'h1234
`define MRB_IDL_RST      16'h5678
`define MRB_ADV_RST      16'h01E1
`define MRB_EXP_RO       16'h001F

// ----------------------------------------------------------------------
// vendor-specific group
// ----------------------------------------------------------------------
`define MRB_MCS_RW       16'h2200
`define MRB_MCS_RO       16'h0002
`define MRB_MCS_EDPD_M   16'h2000
`define MRB_MCS_FLB_M    16'h0200
`define MRB_SMD_RW       16'h40FF
`define MRB_SMD_RST      16'h00E1
`define MRB_CSI_RW       16'h8008
`define MRB_CSI_KEEP     16'h0008
`define MRB_CSI_SS       16'h4000
`define MRB_CSI_WO       16'h0800
`define MRB_CSI_WAC_M    16'h0020
`define MRB_CSI_WC_M     16'h0010
`define MRB_ISR_RC       16'h00FE
`define MRB_IMR_RW       16'h00FE
`define MRB_SCS_RW       16'h0040
`define MRB_SCS_RO       16'h101C

`endif

// ---- core/mrb_attr_reg.v ----
// one 16-bit management register whose bits carry per-bit access attributes
`timescale 1ns/1ps
module mrb_attr_reg #(
  parameter [15:0] P_RST  = 16'h0000,
  parameter [15:0] P_RW   = 16'h0000,
  parameter [15:0] P_WO   = 16'h0000,
  parameter [15:0] P_RO   = 16'h0000,
  parameter [15:0] P_SC   = 16'h0000,
  parameter [15:0] P_SS   = 16'h0000,
  parameter [15:0] P_WC   = 16'h0000,
  parameter [15:0] P_WAC  = 16'h0000,
  parameter [15:0] P_LH   = 16'h0000,
  parameter [15:0] P_LL   = 16'h0000,
  parameter [15:0] P_KEEP = 16'h0000
) (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire        sw_rst_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire [15:0] wdata_i,
  input  wire [15:0] hw_i,
  output wire [15:0] q_o,
  output wire [15:0] rdata_o
);

  // ----------------------------------------------------------------------
  // per-bit next value
  // ----------------------------------------------------------------------
  localparam [15:0] STORED = P_RW | P_WO | P_SC | P_SS | P_WC | P_WAC | P_LH | P_LL;

  reg  [15:0] val_q;
  wire [15:0] val_d;

  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_bit
      // each bit picks its behaviour from the attribute masks
      assign val_d[i] =
        (P_RW[i] | P_WO[i]) ? (wr_i ? wdata_i[i] : val_q[i]) :
        P_SC[i]  ? ((wr_i & wdata_i[i]) | (val_q[i] & ~hw_i[i])) :
        P_SS[i]  ? (~(wr_i & ~wdata_i[i]) & (val_q[i] | hw_i[i])) :
        P_WC[i]  ? (hw_i[i] | (val_q[i] & ~(wr_i & wdata_i[i]))) :
        P_WAC[i] ? (hw_i[i] | (val_q[i] & ~wr_i)) :
        P_LH[i]  ? (hw_i[i] | (val_q[i] & ~rd_i)) :
        P_LL[i]  ? (hw_i[i] & (val_q[i] | rd_i)) :
        1'b0;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // storage: hardware reset loads all, soft reset spares the kept bits
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      val_q <= P_RST & STORED;
    end else if (sw_rst_i) begin
      val_q <= ((val_q & P_KEEP) | (P_RST & ~P_KEEP)) & STORED;
    end else begin
      val_q <= val_d & STORED;
    end
  end

  assign q_o = val_q;
  // read-only bits show the live input, write-only and reserved bits read zero
  assign rdata_o = (hw_i & P_RO) | (val_q & STORED & ~P_WO);

endmodule // mrb_attr_reg

// ---- core/mrb_bank.v ----
// management register bank of a 10/100 transceiver, reached by register index
`timescale 1ns/1ps
`include "mrb_defs.vh"

// Overview of operation
// - registers selected by their management index
// - decode indices 0-6, 17, 18, 26, 27, 29-31 map
// - read-only bits ignore writes, show value
// - write-only bits read back as zero
// - write one clears, zero leaves bit
// - any write clears, read shows value
// - read clears contents, writes ignored
// - latched bits released only by read
// - latch-high holds one until read
// - self-clearing bits drop by themselves
// - self-setting bits rise by themselves
// - kept bits survive software reset
// - read/write bits store and return value
// - software reset restores defaults, power-down not
// - soft reset bit clears itself promptly
module mrb_bank (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire        mgmt_req_i,
  input  wire        mgmt_we_i,
  input  wire [4:0]  mgmt_idx_i,
  input  wire [15:0] mgmt_wdata_i,
  output wire        mgmt_ack_o,
  output wire [15:0] mgmt_rdata_o,
  input  wire        link_up_i,
  input  wire        remote_fault_i,
  input  wire        jabber_i,
  input  wire        aneg_done_i,
  input  wire [15:0] partner_ability_i,
  input  wire [15:0] expansion_i,
  input  wire        energy_on_i,
  input  wire        symbol_err_i,
  input  wire [1:0]  ind_event_i,
  input  wire [6:0]  irq_event_i,
  input  wire [2:0]  speed_ind_i,
  output wire        soft_reset_o,
  output wire        loopback_o,
  output wire        speed_sel_o,
  output wire        aneg_enable_o,
  output wire        power_down_o,
  output wire        isolate_o,
  output wire        aneg_restart_o,
  output wire        duplex_o,
  output wire        edpd_enable_o,
  output wire        far_loopback_o,
  output wire [15:0] advertise_o,
  output wire [15:0] special_modes_o,
  output wire [15:0] ind_control_o,
  output wire [15:0] irq_mask_o,
  output wire [15:0] special_control_o
);

  // ----------------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------------
  // one request is one completed transaction; the index picks the register
  wire wr_en = mgmt_req_i & mgmt_we_i;
  wire rd_en = mgmt_req_i & ~mgmt_we_i;

  wire wr_ctl = wr_en & (mgmt_idx_i == `MRB_IDX_CTL);
  wire wr_idh = wr_en & (mgmt_idx_i == `MRB_IDX_IDH);
  wire wr_idl = wr_en & (mgmt_idx_i == `MRB_IDX_IDL);
  wire wr_adv = wr_en & (mgmt_idx_i == `MRB_IDX_ADV);
  wire wr_mcs = wr_en & (mgmt_idx_i == `MRB_IDX_MCS);
  wire wr_smd = wr_en & (mgmt_idx_i == `MRB_IDX_SMD);
  wire wr_csi = wr_en & (mgmt_idx_i == `MRB_IDX_CSI);
  wire wr_imr = wr_en & (mgmt_idx_i == `MRB_IDX_IMR);
  wire wr_scs = wr_en & (mgmt_idx_i == `MRB_IDX_SCS);

  // clear-on-read strobes fire only for the addressed register
  wire rd_sts = rd_en & (mgmt_idx_i == `MRB_IDX_STS);
  wire rd_sec = rd_en & (mgmt_idx_i == `MRB_IDX_SEC);
  wire rd_isr = rd_en & (mgmt_idx_i == `MRB_IDX_ISR);

  // ----------------------------------------------------------------------
  // soft reset
  // ----------------------------------------------------------------------
  wire [15:0] ctl_q;
  wire [15:0] ctl_rd;
  // the set soft-reset bit resets every register but the kept bits on the next edge, itself
  // included, so it is seen for exactly one cycle; far inside the allowed time
  wire sw_rst = |(ctl_q & `MRB_CTL_SRST_M);

  // ----------------------------------------------------------------------
  // basic group
  // ----------------------------------------------------------------------
  // self-clearing bits see their own value as the done condition
  mrb_attr_reg #(.P_RST(`MRB_CTL_RST), .P_RW(`MRB_CTL_RW), .P_SC(`MRB_CTL_SC)) u_ctl (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_rst_i(sw_rst),
    .wr_i(wr_ctl), .rd_i(1'b0), .wdata_i(mgmt_wdata_i),
    .hw_i(ctl_q & `MRB_CTL_SC), .q_o(ctl_q), .rdata_o(ctl_rd));

  wire [15:0] sts_hw = `MRB_STS_CAPS
                     | ({16{aneg_done_i}}    & `MRB_STS_ANDN_M)
                     | ({16{remote_fault_i}} & `MRB_STS_RFLT_M)
                     | ({16{link_up_i}}      & `MRB_STS_LINK_M)
                     | ({16{jabber_i}}       & `MRB_STS_JAB_M);
  wire [15:0] sts_rd;
  // status has no writable bit, so writes to it are dropped
  mrb_attr_reg #(.P_RO(`MRB_STS_RO), .P_LH(`MRB_STS_LH), .P_LL(`MRB_STS_LL)) u_sts (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_rst_i(sw_rst),
    .wr_i(1'b0), .rd_i(rd_sts), .wdata_i(mgmt_wdata_i),
    .hw_i(sts_hw), .q_o(), .rdata_o(sts_rd));

  // ----------------------------------------------------------------------
  // extended group
  // ----------------------------------------------------------------------
  wire [15:0] idh_rd;
  wire [15:0] idl_rd;
  wire [15:0] adv_q;
  wire [15:0] adv_rd;

  mrb_attr_reg #(.P_RST(`MRB_IDH_RST), .P_RW(`MRB_ONES)) u_idh (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_rst_i(sw_rst),
    .wr_i(wr_idh), .rd_i(1'b0), .wdata_i(mgmt_wdata_i),
    .hw_i(`MRB_ZERO), .q_o(), .rdata_o(idh_rd));

  mrb_attr_reg #(.P_RST(`MRB_IDL_RST), .P_RW(`MRB_ONES)) u_idl (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_rst_i(sw_rst),
    .wr_i(wr_idl), .rd_i(1'b0), .wdata_i(mgmt_wdata_i),
    .hw_i(`MRB_ZERO), .q_o(), .rdata_o(idl_rd));

  mrb_attr_reg #(.P_RST(`MRB_ADV_RST), .P_RW(`MRB_ONES)) u_adv (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_rst_i(sw_rst),
    .wr_i(wr_adv), .rd_i(1'b0), .wdata_i(mgmt_wdata_i),
    .hw_i(`MRB_ZERO), .q_o(adv_q), .rdata_o(adv_rd));

  // ----------------------------------------------------------------------
  // vendor-specific group
  // ----------------------------------------------------------------------
  wire [15:0] mcs_q;
  wire [15:0] mcs_rd;
  wire [15:0] smd_q;
  wire [15:0] smd_rd;
  wire [15:0] csi_q;
  wire [15:0] csi_rd;
  wire [15:0] isr_rd;
  wire [15:0] imr_q;
  wire [15:0] imr_rd;
  wire [15:0] scs_q;
  wire [15:0] scs_rd;

  mrb_attr_reg #(.P_RW(`MRB_MCS_RW), .P_RO(`MRB_MCS_RO)) u_mcs (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_rst_i(sw_rst),
    .wr_i(wr_mcs), .rd_i(1'b0), .wdata_i(mgmt_wdata_i),
    .hw_i({16{energy_on_i}} & `MRB_MCS_RO), .q_o(mcs_q), .rdata_o(mcs_rd));

  // strap-like mode bits are kept across a software reset
  mrb_attr_reg #(.P_RST(`MRB_SMD_RST), .P_RW(`MRB_SMD_RW), .P_KEEP(`MRB_SMD_RW)) u_smd (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_rst_i(sw_rst),
    .wr_i(wr_smd), .rd_i(1'b0), .wdata_i(mgmt_wdata_i),
    .hw_i(`MRB_ZERO), .q_o(smd_q), .rdata_o(smd_rd));

  // self-setting bit sees its own cleared state as the done condition
  wire [15:0] csi_hw = (~csi_q & `MRB_CSI_SS)
                     | ({16{ind_event_i[1]}} & `MRB_CSI_WAC_M)
                     | ({16{ind_event_i[0]}} & `MRB_CSI_WC_M);
  mrb_attr_reg #(.P_RST(`MRB_CSI_SS), .P_RW(`MRB_CSI_RW), .P_KEEP(`MRB_CSI_KEEP),
                 .P_SS(`MRB_CSI_SS), .P_WO(`MRB_CSI_WO),
                 .P_WAC(`MRB_CSI_WAC_M), .P_WC(`MRB_CSI_WC_M)) u_csi (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_rst_i(sw_rst),
    .wr_i(wr_csi), .rd_i(1'b0), .wdata_i(mgmt_wdata_i),
    .hw_i(csi_hw), .q_o(csi_q), .rdata_o(csi_rd));

  // event flags cleared by reading, set wins over the clear
  mrb_attr_reg #(.P_LH(`MRB_ISR_RC)) u_isr (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_rst_i(sw_rst),
    .wr_i(1'b0), .rd_i(rd_isr), .wdata_i(mgmt_wdata_i),
    .hw_i({8'h00, irq_event_i, 1'b0}), .q_o(), .rdata_o(isr_rd));

  mrb_attr_reg #(.P_RW(`MRB_IMR_RW)) u_imr (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_rst_i(sw_rst),
    .wr_i(wr_imr), .rd_i(1'b0), .wdata_i(mgmt_wdata_i),
    .hw_i(`MRB_ZERO), .q_o(imr_q), .rdata_o(imr_rd));

  mrb_attr_reg #(.P_RW(`MRB_SCS_RW), .P_RO(`MRB_SCS_RO)) u_scs (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_rst_i(sw_rst),
    .wr_i(wr_scs), .rd_i(1'b0), .wdata_i(mgmt_wdata_i),
    .hw_i({3'h0, aneg_done_i, 7'h00, speed_ind_i, 2'h0}),
    .q_o(scs_q), .rdata_o(scs_rd));

  // ----------------------------------------------------------------------
  // symbol error counter
  // ----------------------------------------------------------------------
  reg  [15:0] sec_q;
  reg  [15:0] sec_d;

  // saturates rather than wraps so a long run is not reported as few
  always @* begin
    sec_d = sec_q;
    if (rd_sec) begin
      sec_d = symbol_err_i ? `MRB_ONE : `MRB_ZERO;
    end else if (symbol_err_i && (sec_q != `MRB_ONES)) begin
      sec_d = sec_q + `MRB_ONE;
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i || sw_rst) begin
      sec_q <= `MRB_ZERO;
    end else begin
      sec_q <= sec_d;
    end
  end

  // ----------------------------------------------------------------------
  // read mux and answer
  // ----------------------------------------------------------------------
  reg  [15:0] rd_mux;
  reg  [15:0] rdata_q;
  reg         ack_q;

  always @* begin
    case (mgmt_idx_i)
      `MRB_IDX_CTL: rd_mux = ctl_rd;
      `MRB_IDX_STS: rd_mux = sts_rd;
      `MRB_IDX_IDH: rd_mux = idh_rd;
      `MRB_IDX_IDL: rd_mux = idl_rd;
      `MRB_IDX_ADV: rd_mux = adv_rd;
      `MRB_IDX_LPA: rd_mux = partner_ability_i;
      `MRB_IDX_EXP: rd_mux = expansion_i & `MRB_EXP_RO;
      `MRB_IDX_MCS: rd_mux = mcs_rd;
      `MRB_IDX_SMD: rd_mux = smd_rd;
      `MRB_IDX_SEC: rd_mux = sec_q;
      `MRB_IDX_CSI: rd_mux = csi_rd;
      `MRB_IDX_ISR: rd_mux = isr_rd;
      `MRB_IDX_IMR: rd_mux = imr_rd;
      `MRB_IDX_SCS: rd_mux = scs_rd;
      default:      rd_mux = `MRB_ZERO;
    endcase
  end

  // read data is the value before any clear-on-read of the same edge
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= `MRB_ZERO;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= mgmt_req_i;
      if (rd_en) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign mgmt_ack_o   = ack_q;
  assign mgmt_rdata_o = rdata_q;

  // ----------------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------------
  assign soft_reset_o      = sw_rst;
  assign loopback_o        = |(ctl_q & `MRB_CTL_LOOP_M);
  assign speed_sel_o       = |(ctl_q & `MRB_CTL_SPD_M);
  assign aneg_enable_o     = |(ctl_q & `MRB_CTL_ANEN_M);
  assign power_down_o      = |(ctl_q & `MRB_CTL_PDN_M);
  assign isolate_o         = |(ctl_q & `MRB_CTL_ISO_M);
  assign aneg_restart_o    = |(ctl_q & `MRB_CTL_ANRS_M);
  assign duplex_o          = |(ctl_q & `MRB_CTL_DPX_M);
  assign edpd_enable_o     = |(mcs_q & `MRB_MCS_EDPD_M);
  assign far_loopback_o    = |(mcs_q & `MRB_MCS_FLB_M);
  assign advertise_o       = adv_q;
  assign special_modes_o   = smd_q;
  assign ind_control_o     = csi_q;
  assign irq_mask_o        = imr_q;
  assign special_control_o = scs_q;

endmodule // mrb_bank

// ---- tb/mrb_bank_asserts.sv ----
// concurrent checks on the ports of the management register bank
`timescale 1ns/1ps
`include "mrb_defs.vh"
module mrb_bank_asserts (
  input wire        ref_clk_i,
  input wire        rst_i,
  input wire        mgmt_req_i,
  input wire        mgmt_we_i,
  input wire [4:0]  mgmt_idx_i,
  input wire [15:0] mgmt_wdata_i,
  input wire        mgmt_ack_o,
  input wire [15:0] mgmt_rdata_o,
  input wire        jabber_i,
  input wire        soft_reset_o,
  input wire        aneg_restart_o,
  input wire        loopback_o,
  input wire [15:0] special_modes_o,
  input wire [15:0] irq_mask_o
);
  // ----------------------------------------------------------------
  // decoded request kinds
  // ----------------------------------------------------------------
  wire rd_take = mgmt_req_i && !mgmt_we_i;
  wire wr_take = mgmt_req_i && mgmt_we_i;
  // holes in the index map
  wire hole = (mgmt_idx_i > 5'h06 && mgmt_idx_i < 5'h11) ||
              (mgmt_idx_i > 5'h12 && mgmt_idx_i < 5'h1A) || mgmt_idx_i == 5'h1C;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_after_req: assert property (mgmt_req_i |=> mgmt_ack_o)
    else $error("no ack one cycle after request");
  chk_ack_no_req: assert property (!mgmt_req_i |=> !mgmt_ack_o)
    else $error("ack without request");
  chk_rdata_hold: assert property (!rd_take |=> $stable(mgmt_rdata_o))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (rd_take && hole |=> mgmt_rdata_o == 16'h0000)
    else $error("unmapped index read nonzero");
  chk_status_caps: assert property (rd_take && mgmt_idx_i == `MRB_IDX_STS
    |=> (mgmt_rdata_o & `MRB_STS_CAPS) == `MRB_STS_CAPS)
    else $error("status ability bits lost");
  chk_mask_write: assert property (wr_take && mgmt_idx_i == `MRB_IDX_IMR && !soft_reset_o
    |=> irq_mask_o == ($past(mgmt_wdata_i) & `MRB_IMR_RW))
    else $error("mask register did not store write");
  chk_restart_pulse: assert property (aneg_restart_o |=> !aneg_restart_o)
    else $error("restart bit did not self clear");
  chk_srst_start: assert property (wr_take && mgmt_idx_i == `MRB_IDX_CTL
    && mgmt_wdata_i[15] && !soft_reset_o |=> soft_reset_o)
    else $error("soft reset not started");
  chk_srst_defaults: assert property (soft_reset_o
    |=> !soft_reset_o && !loopback_o && irq_mask_o == 16'h0000)
    else $error("soft reset left values or did not end");
  chk_srst_keep: assert property (soft_reset_o
    |=> ((special_modes_o ^ $past(special_modes_o)) & `MRB_SMD_RW) == 16'h0000)
    else $error("kept bits changed by soft reset");
  chk_jabber_held: assert property (rd_take && mgmt_idx_i == `MRB_IDX_STS
    && $past(jabber_i) |=> mgmt_rdata_o[1])
    else $error("jabber latch not reported");

  cover property (soft_reset_o);
  cover property (rd_take && mgmt_idx_i == `MRB_IDX_ISR);
  cover property (aneg_restart_o);
endmodule // mrb_bank_asserts

bind mrb_bank mrb_bank_asserts i_mrb_bank_asserts (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .mgmt_req_i(mgmt_req_i), .mgmt_we_i(mgmt_we_i),
  .mgmt_idx_i(mgmt_idx_i), .mgmt_wdata_i(mgmt_wdata_i), .mgmt_ack_o(mgmt_ack_o),
  .mgmt_rdata_o(mgmt_rdata_o), .jabber_i(jabber_i), .soft_reset_o(soft_reset_o),
  .aneg_restart_o(aneg_restart_o), .loopback_o(loopback_o),
  .special_modes_o(special_modes_o), .irq_mask_o(irq_mask_o));

// ---- tb/mrb_mgmt_ctl.sv ----
// station management controller model issuing register accesses
`timescale 1ns/1ps
module mrb_mgmt_ctl (
  input  wire        ref_clk_i,
  input  wire        ack_i,
  input  wire [15:0] rdata_i,
  output reg         req_o,
  output reg         we_o,
  output reg  [4:0]  idx_o,
  output reg  [15:0] wdata_o
);
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    idx_o = 5'h00;
    wdata_o = 16'h0000;
  end

  // ----------------------------------------------------------------
  // one access: a one-cycle request, then a bounded wait for ack
  // ----------------------------------------------------------------
  // callers may set reserved fields in d, which goes out unmasked
  task access(input logic w, input logic [4:0] i, input logic [15:0] d,
              output logic [15:0] q, output logic late);
    int n;
    begin
      late = 1'b1;
      q = 16'h0000;
      @(posedge ref_clk_i);
      req_o <= 1'b1;
      we_o <= w;
      idx_o <= i; // index travels with the request
      wdata_o <= d;
      @(posedge ref_clk_i);
      // released lines show junk so stale values are never trusted
      req_o <= 1'b0;
      we_o <= ~w;
      idx_o <= ~i;
      wdata_o <= ~d;
      for (n = 0; n < 4 && late; n++) begin
        @(posedge ref_clk_i);
        if (ack_i === 1'b1) begin
          q = rdata_i;
          late = 1'b0;
        end
      end
    end
  endtask
endmodule // mrb_mgmt_ctl

// ---- tb/mrb_bank_test.sv ----
// self-checking testbench of the management register bank
`timescale 1ns/1ps
module mrb_bank_test;
  typedef struct packed {
    logic        w;
    logic [4:0]  i;
    logic [15:0] d;
  } mrb_row_t;

  logic        clk = 1'b0, rst = 1'b1, link = 1'b0, rflt = 1'b0, jab = 1'b0;
  logic        andn = 1'b0, eon = 1'b0, serr = 1'b0;
  logic [15:0] pab = 16'hA5C3, expn = 16'hFFFF, q;
  logic [1:0]  ind = 2'b00;
  logic [6:0]  irq = 7'h00;
  logic [2:0]  spd = 3'h0;
  wire         req, we, ack, edpd, flb;
  wire  [7:0]  cbit;
  wire  [15:0] adv, csiq, scsq;
  wire  [4:0]  idx;
  wire  [15:0] wdata, rdata;
  int          failures = 0;
  int          check_count = 0;

  // reads carry the expected word in d, writes the data
  localparam mrb_row_t rows [22] = '{
    '{1'b0, 5'h02, 16'h1234}, '{1'b0, 5'h03, 16'h5678}, '{1'b0, 5'h00, 16'h3100},
    '{1'b0, 5'h04, 16'h01E1}, '{1'b0, 5'h12, 16'h00E1}, '{1'b0, 5'h1B, 16'h4000},
    '{1'b0, 5'h06, 16'h001F}, '{1'b0, 5'h05, 16'hA5C3}, '{1'b1, 5'h1E, 16'h00AA},
    '{1'b0, 5'h1E, 16'h00AA}, '{1'b1, 5'h11, 16'h2200}, '{1'b0, 5'h11, 16'h2200},
    '{1'b1, 5'h07, 16'hFFFF}, '{1'b0, 5'h07, 16'h0000}, '{1'b1, 5'h01, 16'hFF3F},
    '{1'b0, 5'h01, 16'h7809}, '{1'b1, 5'h1F, 16'h0040}, '{1'b0, 5'h1F, 16'h0040},
    '{1'b0, 5'h10, 16'h0000}, '{1'b0, 5'h1C, 16'h0000}, '{1'b1, 5'h12, 16'h40FF},
    '{1'b0, 5'h12, 16'h40FF}};

  always #25 clk = ~clk;

  mrb_bank i_mrb_bank (
    .ref_clk_i(clk), .rst_i(rst), .mgmt_req_i(req), .mgmt_we_i(we), .mgmt_idx_i(idx),
    .mgmt_wdata_i(wdata), .mgmt_ack_o(ack), .mgmt_rdata_o(rdata), .link_up_i(link),
    .remote_fault_i(rflt), .jabber_i(jab), .aneg_done_i(andn), .partner_ability_i(pab),
    .expansion_i(expn), .energy_on_i(eon), .symbol_err_i(serr), .ind_event_i(ind),
    .irq_event_i(irq), .speed_ind_i(spd), .soft_reset_o(cbit[7]), .loopback_o(cbit[6]),
    .speed_sel_o(cbit[5]), .aneg_enable_o(cbit[4]), .power_down_o(cbit[3]),
    .isolate_o(cbit[2]), .aneg_restart_o(cbit[1]), .duplex_o(cbit[0]),
    .edpd_enable_o(edpd), .far_loopback_o(flb), .advertise_o(adv), .special_modes_o(),
    .ind_control_o(csiq), .irq_mask_o(), .special_control_o(scsq));

  mrb_mgmt_ctl i_mrb_mgmt_ctl (
    .ref_clk_i(clk), .ack_i(ack), .rdata_i(rdata), .req_o(req), .we_o(we),
    .idx_o(idx), .wdata_o(wdata));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task tally_and_finish;
    begin
      if (failures == 0 && check_count > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    begin
      check_count++;
      if (g !== e) begin
        failures++;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // a missing ack ends the run as a mismatch
  task xfer(input logic w, input logic [4:0] i, input logic [15:0] d);
    logic late;
    begin
      i_mrb_mgmt_ctl.access(w, i, d, q, late);
      chk("ack", 16'h0001, {15'h0000, ~late});
      if (late !== 1'b0) begin
        tally_and_finish;
      end
    end
  endtask

  task rd(input logic [4:0] i, input logic [15:0] e);
    begin
      xfer(1'b0, i, 16'h0000);
      chk($sformatf("index %h", i), e, q);
    end
  endtask

  task do_reset;
    begin
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // table pass, then latch, clear and reset cases
  // ----------------------------------------------------------------
  initial begin
    do_reset;
    foreach (rows[n]) begin
      if (rows[n].w) begin
        xfer(1'b1, rows[n].i, rows[n].d);
      end else begin
        rd(rows[n].i, rows[n].d);
      end
    end
    chk("edpd and far loop", 16'h0003, {14'h0000, edpd, flb});
    chk("advertise out", 16'h01E1, adv);
    chk("special control out", 16'h0040, scsq);
    // live read-only inputs show through, then go back to idle
    {eon, andn, spd} <= 5'h1D;
    rd(5'h11, 16'h2202);
    rd(5'h1F, 16'h1054);
    rd(5'h01, 16'h7829);
    {eon, andn, spd} <= 5'h00;
    // one-cycle faults must survive an unrelated read
    @(posedge clk) {jab, rflt} <= 2'b11;
    @(posedge clk) {jab, rflt} <= 2'b00;
    rd(5'h00, 16'h3100);
    rd(5'h01, 16'h781B);
    rd(5'h01, 16'h7809);
    // link drop is held low until read
    link <= 1'b1;
    xfer(1'b0, 5'h01, 16'h0000);
    rd(5'h01, 16'h780D);
    @(posedge clk) link <= 1'b0;
    @(posedge clk) link <= 1'b1;
    rd(5'h01, 16'h7809);
    rd(5'h01, 16'h780D);
    // counter and sources clear on read, counter ignores writes
    @(posedge clk) {serr, irq} <= {1'b1, 7'h55};
    @(posedge clk) irq <= 7'h00;
    repeat (2) @(posedge clk);
    serr <= 1'b0;
    xfer(1'b1, 5'h1A, 16'hFFFF);
    rd(5'h1A, 16'h0003);
    rd(5'h1A, 16'h0000);
    rd(5'h1D, 16'h00AA);
    rd(5'h1D, 16'h0000);
    // write-one and write-any clears, self-set and write-only bits
    @(posedge clk) ind <= 2'b11;
    @(posedge clk) ind <= 2'b00;
    rd(5'h1B, 16'h4030);
    xfer(1'b1, 5'h1B, 16'h4000);
    rd(5'h1B, 16'h4010);
    xfer(1'b1, 5'h1B, 16'h4010);
    rd(5'h1B, 16'h4000);
    xfer(1'b1, 5'h1B, 16'h0800);
    rd(5'h1B, 16'h4000);
    xfer(1'b1, 5'h00, 16'h3300);
    rd(5'h00, 16'h3100);
    // power down keeps registers
    xfer(1'b1, 5'h1E, 16'h0002);
    xfer(1'b1, 5'h00, 16'h3900);
    chk("control outs", 16'h0039, {8'h00, cbit});
    rd(5'h1E, 16'h0002);
    // soft reset restores all but the kept bits
    xfer(1'b1, 5'h1B, 16'h4008);
    xfer(1'b1, 5'h00, 16'h8000);
    rd(5'h00, 16'h3100);
    chk("control outs", 16'h0031, {8'h00, cbit});
    rd(5'h1E, 16'h0000);
    rd(5'h11, 16'h0000);
    rd(5'h12, 16'h40FF);
    rd(5'h1B, 16'h4008);
    chk("indication out", 16'h4008, csiq);
    do_reset;
    rd(5'h12, 16'h00E1);
    rd(5'h1B, 16'h4000);
    tally_and_finish;
  end
endmodule // mrb_bank_test
